/* File: pkg/priv_pkg.sv */
// constants and types for the cpu privilege mode and memory partition control
package priv_pkg;

    // cpu operating modes; boot, test and firmware form the super-system level
    typedef enum logic [2:0] {
        MODE_BOOT,
        MODE_TEST,
        MODE_FIRMWARE,
        MODE_SYSTEM,
        MODE_USER
    } cpu_mode_e;

    // memory space selects of an access request
    localparam int         ADDR_W     = 19;
    localparam logic [1:0] MEM_ROM    = 2'h0;
    localparam logic [1:0] MEM_EEPROM = 2'h1;
    localparam logic [1:0] MEM_RAM    = 2'h2;
    localparam logic [1:0] MEM_SFR    = 2'h3;

    // partition sizes in bytes
    localparam int ROM_TEST_BYTES    = 128 * 1024;
    localparam int ROM_APP_BYTES_DEF = 384 * 1024;
    localparam int ROM_APP_BYTES_ALT = 300 * 1024;
    localparam int EEPROM_BYTES      = 80 * 1024;
    localparam int EE_MFR_BYTES      = 512;
    localparam int EE_SUPPORT_BYTES  = 768;
    localparam int EE_SUPER_BYTES    = EE_MFR_BYTES + EE_SUPPORT_BYTES;
    localparam int RAM_BYTES         = 8320;
    localparam int RAM_FW_BYTES      = 512;
    localparam int SFR_COUNT         = 32;

    // fixed vector table in rom
    localparam logic [ADDR_W-1:0] EXC_VEC_BASE = 19'h20000;
    localparam logic [ADDR_W-1:0] IRQ_VEC_BASE = 19'h20020;
    localparam logic [ADDR_W-1:0] SVC_VEC_BASE = 19'h200A0;
    localparam logic [ADDR_W-1:0] FW_VEC_BASE  = 19'h20120;
    localparam int                VEC_STRIDE   = 4;
    localparam int                FW_VEC_COUNT = 8;
    localparam int                SVC_VEC_COUNT = 32;
    localparam logic [2:0]        EXC_ID_ACCESS = 3'h0;

    // watchdog
    localparam int          WDT_W          = 16;
    localparam logic [15:0] WDT_RELOAD_RST = 16'hFFFF;

endpackage : priv_pkg

/* File: rtl/region_check.sv */
// range and low-partition decode of one memory space
`timescale 1ns/1ns
module region_check #(
    parameter int AW    = 19,
    parameter int TOTAL = 1,
    parameter int LOW   = 0
) (
    input  wire logic [AW-1:0] addr,
    output logic               in_range,
    output logic               in_low
);

    // offsets below TOTAL exist, offsets below LOW are the reserved partition
    assign in_range = 32'(addr) < 32'(TOTAL);
    assign in_low   = 32'(addr) < 32'(LOW);

endmodule : region_check

/* File: rtl/wdt_guard.sv */
// software enabled watchdog that flags runaway execution
`timescale 1ns/1ns
module wdt_guard #(
    parameter int CNT_W = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             cfg_we,
    input  wire logic             cfg_enable,
    input  wire logic [CNT_W-1:0] cfg_reload,
    input  wire logic             kick,
    output logic                  expire_r,
    output logic                  enabled_r
);

    logic [CNT_W-1:0] reload_r;
    logic [CNT_W-1:0] count_r;

    // enable and reload; idle after reset and after each expiry
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            enabled_r <= 1'b0;
            reload_r  <= CNT_W'(priv_pkg::WDT_RELOAD_RST);
        end else if (cfg_we) begin
            enabled_r <= cfg_enable;
            reload_r  <= cfg_reload;
        end else if (expire_r) begin
            enabled_r <= 1'b0;
        end
    end

    // down counter, restarted by config or kick
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_r  <= '0;
            expire_r <= 1'b0;
        end else begin
            expire_r <= 1'b0;
            if (cfg_we || kick || !enabled_r) begin
                count_r <= cfg_we ? cfg_reload : reload_r;
            end else if (count_r == '0) begin
                expire_r <= 1'b1;
                count_r  <= reload_r;
            end else begin
                count_r <= count_r - CNT_W'(1);
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_WDT_QUIET: assert property (!enabled_r |=> !expire_r)
        else $error("watchdog fired while disabled");

endmodule : wdt_guard

/* File: rtl/cpu_privilege_mode_control.sv */
// cpu privilege mode sequencing, vector dispatch and memory partition checks
//
// Behaviour
// - five modes; boot, test, firmware are super-system
// - super-system is always boot, test or firmware
// - customer code never enters test, and enters boot only by watchdog abort
// - test enabled: reset ends in test mode
// - test disabled: reset ends in system mode
// - system mode reaches all customer resources
// - user mode limited by system-granted permissions
// - exceptions and interrupts jump to fixed vectors
// - eight firmware vectors enter firmware mode
// - 32 system call vectors enter system mode
// - mmu splits rom, ram, eeprom in two
// - largest sizes 512k rom, 8.125k ram, 80k eeprom
// - rom: 128k test plus 300/384k application
// - eeprom reserves 512 plus 768 bytes
// - ram: 512 bytes firmware, rest application
// - watchdog aborts runaway code once enabled
// - test unrestricted; boot/firmware only reserved parts plus all sfrs
// - user checked by mmu, configured in system
`timescale 1ns/1ns
module cpu_privilege_mode_control #(
    parameter int ROM_APP_BYTES = priv_pkg::ROM_APP_BYTES_DEF
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic                        test_mode_disabled,
    input  wire logic                        boot_done,
    input  wire logic                        jump_valid,
    input  wire logic                        jump_explicit,
    input  wire logic [priv_pkg::ADDR_W-1:0] jump_target,
    input  wire logic                        ret_valid,
    input  wire logic                        ret_to_user,
    input  wire logic                        exc_req,
    input  wire logic [2:0]                  exc_id,
    input  wire logic                        irq_req,
    input  wire logic [4:0]                  irq_id,
    input  wire logic                        acc_valid,
    input  wire logic [1:0]                  acc_mem,
    input  wire logic [priv_pkg::ADDR_W-1:0] acc_addr,
    input  wire logic                        acc_write,
    input  wire logic                        mmu_cfg_we,
    input  wire logic [1:0]                  mmu_cfg_mem,
    input  wire logic [priv_pkg::ADDR_W-1:0] mmu_cfg_base,
    input  wire logic [priv_pkg::ADDR_W-1:0] mmu_cfg_limit,
    input  wire logic                        mmu_cfg_wr_ok,
    input  wire logic [31:0]                 mmu_cfg_sfr_mask,
    input  wire logic                        wdt_cfg_we,
    input  wire logic                        wdt_cfg_enable,
    input  wire logic [priv_pkg::WDT_W-1:0]  wdt_cfg_reload,
    input  wire logic                        wdt_kick,
    output priv_pkg::cpu_mode_e              cpu_mode_r,
    output logic                             super_system_r,
    output logic                             acc_grant_r,
    output logic                             acc_fault_r,
    output logic                             vector_valid_r,
    output logic [priv_pkg::ADDR_W-1:0]      vector_addr_r,
    output logic                             cfg_reject_r,
    output logic                             wdt_abort_r,
    output logic                             wdt_active_r
);

    localparam int AW = priv_pkg::ADDR_W;
    localparam int REG_TOTAL [4] = '{priv_pkg::ROM_TEST_BYTES + ROM_APP_BYTES,
                                     priv_pkg::EEPROM_BYTES, priv_pkg::RAM_BYTES,
                                     priv_pkg::SFR_COUNT};
    localparam int REG_LOW [4]   = '{priv_pkg::ROM_TEST_BYTES, priv_pkg::EE_SUPER_BYTES,
                                     priv_pkg::RAM_FW_BYTES, 0};
    localparam logic [AW-1:0] FW_SPAN  = AW'(priv_pkg::FW_VEC_COUNT * priv_pkg::VEC_STRIDE);
    localparam logic [AW-1:0] SVC_SPAN = AW'(priv_pkg::SVC_VEC_COUNT * priv_pkg::VEC_STRIDE);

    priv_pkg::cpu_mode_e mode_nxt;
    priv_pkg::cpu_mode_e fw_return_r;
    logic [3:0]          in_range;
    logic [3:0]          in_low;
    logic [AW-1:0]       usr_base_r [0:2];
    logic [AW-1:0]       usr_limit_r [0:2];
    logic [2:0]          usr_wr_ok_r;
    logic [31:0]         usr_sfr_ok_r;
    logic [AW-1:0]       fw_off;
    logic [AW-1:0]       svc_off;
    logic                fw_hit;
    logic                svc_hit;
    logic                customer_mode;
    logic                user_ok;
    logic                acc_ok;
    logic                acc_deny;
    logic                wdt_fire;

    // one range decoder per memory space
    for (genvar g = 0; g < 4; g++) begin : g_region
        region_check #(
            .AW    (AW),
            .TOTAL (REG_TOTAL[g]),
            .LOW   (REG_LOW[g])
        ) u_check (
            .addr     (acc_addr),
            .in_range (in_range[g]),
            .in_low   (in_low[g])
        );
    end

    // watchdog, configurable from system mode only
    wdt_guard #(
        .CNT_W (priv_pkg::WDT_W)
    ) u_wdt (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .cfg_we     (wdt_cfg_we && cpu_mode_r == priv_pkg::MODE_SYSTEM),
        .cfg_enable (wdt_cfg_enable),
        .cfg_reload (wdt_cfg_reload),
        .kick       (wdt_kick),
        .expire_r   (wdt_fire),
        .enabled_r  (wdt_active_r)
    );

    // vector decode of an explicit call
    assign customer_mode = cpu_mode_r == priv_pkg::MODE_SYSTEM ||
                           cpu_mode_r == priv_pkg::MODE_USER;
    assign fw_off  = jump_target - priv_pkg::FW_VEC_BASE;
    assign svc_off = jump_target - priv_pkg::SVC_VEC_BASE;
    assign fw_hit  = jump_valid && jump_explicit && customer_mode &&
                     fw_off < FW_SPAN && fw_off[1:0] == 2'h0;
    assign svc_hit = jump_valid && jump_explicit && customer_mode &&
                     svc_off < SVC_SPAN && svc_off[1:0] == 2'h0;

    // user permission from the mmu windows
    always_comb begin
        user_ok = 1'b0;
        if (acc_mem == priv_pkg::MEM_SFR) begin
            user_ok = usr_sfr_ok_r[acc_addr[4:0]];
        end else begin
            user_ok = acc_addr >= usr_base_r[acc_mem] &&
                      acc_addr <= usr_limit_r[acc_mem] &&
                      (!acc_write || usr_wr_ok_r[acc_mem]);
        end
    end

    // partition check per mode
    always_comb begin
        acc_ok = 1'b0;
        case (cpu_mode_r)
            priv_pkg::MODE_TEST: begin
                acc_ok = in_range[acc_mem];
            end
            priv_pkg::MODE_BOOT, priv_pkg::MODE_FIRMWARE: begin
                acc_ok = in_range[acc_mem] &&
                         (in_low[acc_mem] || acc_mem == priv_pkg::MEM_SFR);
            end
            priv_pkg::MODE_SYSTEM: begin
                acc_ok = in_range[acc_mem] && !in_low[acc_mem];
            end
            priv_pkg::MODE_USER: begin
                acc_ok = in_range[acc_mem] && !in_low[acc_mem] && user_ok;
            end
            default: begin
                acc_ok = 1'b0;
            end
        endcase
        if (acc_write && acc_mem == priv_pkg::MEM_ROM) begin
            acc_ok = 1'b0;
        end
    end

    assign acc_deny = acc_valid && !acc_ok;

    // next mode, watchdog abort first
    always_comb begin
        mode_nxt = cpu_mode_r;
        case (cpu_mode_r)
            priv_pkg::MODE_BOOT: begin
                if (boot_done) begin
                    mode_nxt = test_mode_disabled ? priv_pkg::MODE_SYSTEM
                                                  : priv_pkg::MODE_TEST;
                end
            end
            priv_pkg::MODE_TEST: begin
                mode_nxt = priv_pkg::MODE_TEST;
            end
            priv_pkg::MODE_FIRMWARE: begin
                if (ret_valid) begin
                    mode_nxt = fw_return_r;
                end
            end
            priv_pkg::MODE_SYSTEM, priv_pkg::MODE_USER: begin
                if (acc_deny || exc_req || irq_req) begin
                    mode_nxt = priv_pkg::MODE_SYSTEM;
                end else if (fw_hit) begin
                    mode_nxt = priv_pkg::MODE_FIRMWARE;
                end else if (svc_hit) begin
                    mode_nxt = priv_pkg::MODE_SYSTEM;
                end else if (ret_valid && ret_to_user) begin
                    mode_nxt = priv_pkg::MODE_USER;
                end
            end
            default: begin
                mode_nxt = priv_pkg::MODE_BOOT;
            end
        endcase
        if (wdt_fire) begin
            mode_nxt = priv_pkg::MODE_BOOT;
        end
    end

    // mode register; super level derived from the sub-mode only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cpu_mode_r     <= priv_pkg::MODE_BOOT;
            super_system_r <= 1'b1;
        end else begin
            cpu_mode_r     <= mode_nxt;
            super_system_r <= mode_nxt == priv_pkg::MODE_BOOT ||
                              mode_nxt == priv_pkg::MODE_TEST ||
                              mode_nxt == priv_pkg::MODE_FIRMWARE;
        end
    end

    // mode to resume when firmware returns
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fw_return_r <= priv_pkg::MODE_SYSTEM;
        end else if (fw_hit && mode_nxt == priv_pkg::MODE_FIRMWARE) begin
            fw_return_r <= cpu_mode_r;
        end
    end

    // access answer one cycle after the request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_grant_r <= 1'b0;
            acc_fault_r <= 1'b0;
        end else begin
            acc_grant_r <= acc_valid && acc_ok;
            acc_fault_r <= acc_deny;
        end
    end

    // event dispatch: access fault, then exception, then interrupt
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vector_valid_r <= 1'b0;
            vector_addr_r  <= '0;
        end else begin
            vector_valid_r <= (acc_deny || exc_req || irq_req) && !wdt_fire;
            if (acc_deny) begin
                vector_addr_r <= priv_pkg::EXC_VEC_BASE +
                                 AW'({priv_pkg::EXC_ID_ACCESS, 2'h0});
            end else if (exc_req) begin
                vector_addr_r <= priv_pkg::EXC_VEC_BASE + AW'({exc_id, 2'h0});
            end else if (irq_req) begin
                vector_addr_r <= priv_pkg::IRQ_VEC_BASE + AW'({irq_id, 2'h0});
            end
        end
    end

    // mmu windows, writable only from system mode
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                usr_base_r[i]  <= '1;
                usr_limit_r[i] <= '0;
            end
            usr_wr_ok_r  <= 3'h0;
            usr_sfr_ok_r <= 32'h0;
            cfg_reject_r <= 1'b0;
        end else begin
            cfg_reject_r <= mmu_cfg_we && cpu_mode_r != priv_pkg::MODE_SYSTEM;
            if (mmu_cfg_we && cpu_mode_r == priv_pkg::MODE_SYSTEM) begin
                if (mmu_cfg_mem == priv_pkg::MEM_SFR) begin
                    usr_sfr_ok_r <= mmu_cfg_sfr_mask;
                end else begin
                    usr_base_r[mmu_cfg_mem]  <= mmu_cfg_base;
                    usr_limit_r[mmu_cfg_mem] <= mmu_cfg_limit;
                    usr_wr_ok_r[mmu_cfg_mem] <= mmu_cfg_wr_ok;
                end
            end
        end
    end

    // watchdog abort flag out
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wdt_abort_r <= 1'b0;
        end else begin
            wdt_abort_r <= wdt_fire;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_RESET_TO_TEST: assert property (
        cpu_mode_r == priv_pkg::MODE_BOOT && boot_done && !test_mode_disabled && !wdt_fire
        |=> cpu_mode_r == priv_pkg::MODE_TEST)
        else $error("boot did not end in test mode");

    AST_RESET_TO_SYSTEM: assert property (
        cpu_mode_r == priv_pkg::MODE_BOOT && boot_done && test_mode_disabled && !wdt_fire
        |=> cpu_mode_r == priv_pkg::MODE_SYSTEM)
        else $error("boot did not end in system mode");

    AST_SUPER_IS_SUBMODE: assert property (
        super_system_r == (cpu_mode_r inside {priv_pkg::MODE_BOOT, priv_pkg::MODE_TEST,
                                              priv_pkg::MODE_FIRMWARE}))
        else $error("super level flag disagrees with mode");

    AST_NO_CUSTOMER_ESCALATE: assert property (
        customer_mode && !wdt_fire
        |=> !(cpu_mode_r inside {priv_pkg::MODE_BOOT, priv_pkg::MODE_TEST}))
        else $error("customer mode reached boot or test");

    AST_FW_ENTRY: assert property (
        fw_hit && !acc_deny && !exc_req && !irq_req && !wdt_fire
        |=> cpu_mode_r == priv_pkg::MODE_FIRMWARE ##1 1'b1)
        else $error("firmware vector did not enter firmware mode");

    AST_SVC_ENTRY: assert property (
        svc_hit && !fw_hit && !wdt_fire |=> cpu_mode_r == priv_pkg::MODE_SYSTEM)
        else $error("system call vector did not enter system mode");

    AST_IMPLICIT_NO_SWITCH: assert property (
        jump_valid && !jump_explicit && !acc_deny && !exc_req && !irq_req && !ret_valid
        && !boot_done && !wdt_fire |=> $stable(cpu_mode_r))
        else $error("implicit jump changed mode");

    AST_FAULT_VECTOR: assert property (
        acc_deny && !wdt_fire |=> acc_fault_r && !acc_grant_r && vector_valid_r
        && vector_addr_r == priv_pkg::EXC_VEC_BASE)
        else $error("blocked access did not raise the fault vector");

    AST_SUPER_PARTITION: assert property (
        acc_valid && cpu_mode_r inside {priv_pkg::MODE_BOOT, priv_pkg::MODE_FIRMWARE}
        && acc_mem != priv_pkg::MEM_SFR && !in_low[acc_mem] |=> acc_fault_r)
        else $error("boot or firmware reached the application partition");

    AST_SYSTEM_PARTITION: assert property (
        acc_valid && cpu_mode_r == priv_pkg::MODE_SYSTEM && acc_mem == priv_pkg::MEM_RAM
        && acc_addr < AW'(priv_pkg::RAM_FW_BYTES) |=> acc_fault_r)
        else $error("system mode reached firmware ram");

    AST_CFG_SYSTEM_ONLY: assert property (
        mmu_cfg_we && cpu_mode_r != priv_pkg::MODE_SYSTEM
        |=> cfg_reject_r && $stable(usr_sfr_ok_r) && $stable(usr_wr_ok_r))
        else $error("mmu changed outside system mode");

    COV_TEST_PATH: cover property (cpu_mode_r == priv_pkg::MODE_BOOT ##1
                                   cpu_mode_r == priv_pkg::MODE_TEST);
    COV_SYSTEM_PATH: cover property (cpu_mode_r == priv_pkg::MODE_BOOT ##1
                                     cpu_mode_r == priv_pkg::MODE_SYSTEM);
    COV_FW_CALL: cover property (cpu_mode_r == priv_pkg::MODE_USER ##1
                                 cpu_mode_r == priv_pkg::MODE_FIRMWARE);
    COV_USER_FAULT: cover property (cpu_mode_r == priv_pkg::MODE_USER && acc_fault_r);

endmodule : cpu_privilege_mode_control

/* File: testbench/cpu_privilege_mode_control_tb.sv */
// self-checking bench for the cpu privilege mode control block
`timescale 1ns/1ns
module cpu_privilege_mode_control_tb;
    logic                        sys_clk, rst, test_mode_disabled, boot_done;
    logic                        jump_valid, jump_explicit, ret_valid, ret_to_user;
    logic                        exc_req, irq_req, acc_valid, acc_write, mmu_cfg_we, mmu_cfg_wr_ok;
    logic                        wdt_cfg_we, wdt_cfg_enable, wdt_kick;
    logic [2:0]                  exc_id;
    logic [4:0]                  irq_id;
    logic [1:0]                  acc_mem, mmu_cfg_mem;
    logic [priv_pkg::ADDR_W-1:0] jump_target, acc_addr, mmu_cfg_base, mmu_cfg_limit;
    logic [31:0]                 mmu_cfg_sfr_mask;
    logic [15:0]                 wdt_cfg_reload;
    priv_pkg::cpu_mode_e         cpu_mode_r;
    logic                        super_system_r, acc_grant_r, acc_fault_r, vector_valid_r;
    logic [priv_pkg::ADDR_W-1:0] vector_addr_r;
    logic                        cfg_reject_r, wdt_abort_r, wdt_active_r;
    int                          num_errors = 0;
    int                          n_tests = 0;
    int                          k;

    cpu_privilege_mode_control i_cpu_privilege_mode_control (.*);

    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // expected vector address of table entry idx
    function automatic logic [18:0] vec(logic [18:0] base, int idx);
        return base + 19'(4 * idx);
    endfunction : vec

    task automatic tick;
        @(negedge sys_clk);
    endtask : tick

    task automatic fail(string m);
        num_errors++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail

    task automatic chk_bit(logic got, logic exp);
        n_tests++;
        if (got !== exp) fail("flag mismatch");
    endtask : chk_bit

    task automatic chk_mode(priv_pkg::cpu_mode_e exp);
        n_tests++;
        if (cpu_mode_r !== exp) fail("mode mismatch");
    endtask : chk_mode

    task automatic chk_vec(logic [18:0] exp);
        n_tests++;
        if (vector_valid_r !== 1'b1 || vector_addr_r !== exp) fail("vector mismatch");
    endtask : chk_vec

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // reset, then end boot with the given test-disable level
    task automatic reset_to(logic dis);
        rst = 1'b1;
        test_mode_disabled = dis;
        repeat (10) tick();
        rst = 1'b0;
        chk_mode(priv_pkg::MODE_BOOT);
        chk_bit(wdt_active_r, 1'b0);
        tick();
        boot_done = 1'b1;
        tick();
        boot_done = 1'b0;
    endtask : reset_to

    task automatic jump(logic [18:0] tgt, logic expl, priv_pkg::cpu_mode_e em);
        jump_valid = 1'b1;
        jump_explicit = expl;
        jump_target = tgt;
        tick();
        jump_valid = 1'b0;
        chk_mode(em);
        tick();
    endtask : jump

    task automatic ret(logic to_user, priv_pkg::cpu_mode_e em);
        ret_valid = 1'b1;
        ret_to_user = to_user;
        tick();
        ret_valid = 1'b0;
        chk_mode(em);
        tick();
    endtask : ret

    task automatic acc(logic [1:0] mem, logic [18:0] a, logic wr, logic g);
        acc_valid = 1'b1;
        acc_mem = mem;
        acc_addr = a;
        acc_write = wr;
        tick();
        acc_valid = 1'b0;
        chk_bit(acc_grant_r, g);
        chk_bit(acc_fault_r, !g);
        if (!g) chk_vec(priv_pkg::EXC_VEC_BASE);
        tick();
    endtask : acc

    task automatic cfg(logic [1:0] mem, logic [18:0] b, logic [18:0] l, logic rej);
        mmu_cfg_we = 1'b1;
        mmu_cfg_mem = mem;
        mmu_cfg_base = b;
        mmu_cfg_limit = l;
        tick();
        mmu_cfg_we = 1'b0;
        chk_bit(cfg_reject_r, rej);
        tick();
    endtask : cfg

    task automatic evt(logic is_irq, int id);
        irq_req = is_irq;
        exc_req = !is_irq;
        irq_id = 5'(id);
        exc_id = 3'(id);
        tick();
        {irq_req, exc_req} = 2'b00;
        if (is_irq) chk_vec(vec(priv_pkg::IRQ_VEC_BASE, id));
        else chk_vec(vec(priv_pkg::EXC_VEC_BASE, id));
        chk_mode(priv_pkg::MODE_SYSTEM);
        tick();
    endtask : evt

    // hang guard
    initial begin
        #400000;
        fail("timeout");
        end_of_test();
    end

    initial begin
        {rst, test_mode_disabled, boot_done, jump_valid, jump_explicit, ret_valid} = '0;
        {ret_to_user, exc_req, irq_req, acc_valid, acc_write, mmu_cfg_we} = '0;
        {wdt_cfg_we, wdt_cfg_enable, wdt_kick, exc_id, irq_id, acc_mem, mmu_cfg_mem} = '0;
        {jump_target, acc_addr, mmu_cfg_base, mmu_cfg_limit, wdt_cfg_reload} = '0;
        mmu_cfg_wr_ok = 1'b1;
        mmu_cfg_sfr_mask = 32'h0;
        void'($urandom(46870));
        // production phase
        reset_to(1'b0);
        chk_mode(priv_pkg::MODE_TEST);
        chk_bit(super_system_r, 1'b1);
        jump(priv_pkg::FW_VEC_BASE, 1'b1, priv_pkg::MODE_TEST);
        acc(priv_pkg::MEM_RAM, 19'h00010, 1'b1, 1'b1);
        $display("test production_reset done");
        // field phase and partitions in system mode
        reset_to(1'b1);
        chk_mode(priv_pkg::MODE_SYSTEM);
        chk_bit(super_system_r, 1'b0);
        acc(priv_pkg::MEM_ROM, 19'h1FFFF, 1'b0, 1'b0);
        acc(priv_pkg::MEM_ROM, 19'h20000, 1'b0, 1'b1);
        acc(priv_pkg::MEM_ROM, 19'h20000, 1'b1, 1'b0);
        acc(priv_pkg::MEM_EEPROM, 19'h004FF, 1'b0, 1'b0);
        acc(priv_pkg::MEM_EEPROM, 19'h00500, 1'b1, 1'b1);
        acc(priv_pkg::MEM_RAM, 19'h001FF, 1'b0, 1'b0);
        acc(priv_pkg::MEM_RAM, 19'h00200, 1'b1, 1'b1);
        acc(priv_pkg::MEM_RAM, 19'h0207F, 1'b0, 1'b1);
        acc(priv_pkg::MEM_RAM, 19'h02080, 1'b0, 1'b0);
        acc(priv_pkg::MEM_SFR, 19'h00005, 1'b1, 1'b1);
        $display("test partitions done");
        // firmware entry
        k = $urandom % 8;
        jump(vec(priv_pkg::FW_VEC_BASE, k), 1'b0, priv_pkg::MODE_SYSTEM);
        jump(vec(priv_pkg::FW_VEC_BASE, k) + 19'h2, 1'b1, priv_pkg::MODE_SYSTEM);
        jump(vec(priv_pkg::FW_VEC_BASE, k), 1'b1, priv_pkg::MODE_FIRMWARE);
        chk_bit(super_system_r, 1'b1);
        acc(priv_pkg::MEM_RAM, 19'h00000, 1'b1, 1'b1);
        acc(priv_pkg::MEM_RAM, 19'h00200, 1'b0, 1'b0);
        acc(priv_pkg::MEM_ROM, 19'h00000, 1'b0, 1'b1);
        ret(1'b0, priv_pkg::MODE_SYSTEM);
        $display("test firmware done");
        // user mode and mmu windows
        ret(1'b1, priv_pkg::MODE_USER);
        acc(priv_pkg::MEM_RAM, 19'h00300, 1'b0, 1'b0);
        chk_mode(priv_pkg::MODE_SYSTEM);
        cfg(priv_pkg::MEM_RAM, 19'h00200, 19'h003FF, 1'b0);
        mmu_cfg_sfr_mask = 32'h00000020;
        cfg(priv_pkg::MEM_SFR, 19'h00000, 19'h00000, 1'b0);
        ret(1'b1, priv_pkg::MODE_USER);
        cfg(priv_pkg::MEM_RAM, 19'h00000, 19'h01FFF, 1'b1);
        for (int i = 0; i < 6; i++) begin
            acc(priv_pkg::MEM_RAM, 19'h00200 + 19'($urandom % 512), 1'($urandom), 1'b1);
        end
        acc(priv_pkg::MEM_SFR, 19'h00005, 1'b0, 1'b1);
        acc(priv_pkg::MEM_RAM, 19'h00400, 1'b0, 1'b0);
        $display("test user_mmu done");
        // system call vectors and event dispatch
        for (int i = 0; i < 32; i++) begin
            ret(1'b1, priv_pkg::MODE_USER);
            jump(vec(priv_pkg::SVC_VEC_BASE, i), 1'b1, priv_pkg::MODE_SYSTEM);
        end
        for (int i = 0; i < 8; i++) begin
            ret(1'b1, priv_pkg::MODE_USER);
            evt(1'b1, $urandom % 32);
            evt(1'b0, $urandom % 8);
        end
        $display("test vectors done");
        // watchdog refused in user, then armed in system until it aborts
        ret(1'b1, priv_pkg::MODE_USER);
        {wdt_cfg_we, wdt_cfg_enable, wdt_cfg_reload} = {1'b1, 1'b1, 16'h0002};
        tick();
        wdt_cfg_we = 1'b0;
        tick();
        chk_bit(wdt_active_r, 1'b0);
        evt(1'b1, 0);
        wdt_cfg_we = 1'b1;
        tick();
        wdt_cfg_we = 1'b0;
        chk_bit(wdt_active_r, 1'b1);
        // one kick restarts the count, so the abort comes a cycle later
        wdt_kick = 1'b1;
        tick();
        wdt_kick = 1'b0;
        k = 0;
        while (wdt_abort_r !== 1'b1 && k < 10) begin
            tick();
            k++;
        end
        if (k == 10) begin
            fail("watchdog wait ran out");
        end
        chk_bit(k == 4, 1'b1);
        chk_mode(priv_pkg::MODE_BOOT);
        tick();
        chk_bit(wdt_abort_r, 1'b0);
        chk_bit(wdt_active_r, 1'b0);
        $display("test watchdog done");
        end_of_test();
    end
endmodule : cpu_privilege_mode_control_tb
